// ---- lsd_core.sv ----
/*
 File: top of the load/store decoder with its register file.
 Assumes: fetch and data bus logic on the same clock; a zero-wait
 access acknowledges in the cycle its request is shown.
*/
`timescale 1ns/1ps
module lsd_core
(
   input wire logic i_ref_clk,            // 20 MHz clock
   input wire logic i_rst_n,              // Async reset, active low
   input wire logic i_insn_valid,         // Opcode offered
   input wire logic [15:0] i_insn,        // Opcode
   input wire logic [31:0] i_insn_pc,     // Opcode address
   input wire logic i_fetch_busy,         // Fetch owns the bus now
   input wire logic i_mem_ack,            // Data access done
   input wire logic [31:0] i_mem_rdata,   // Read data, low aligned
   output logic o_insn_ready,             // Opcode will be taken
   output logic o_mem_req,                // Data access request
   output logic o_mem_we,                 // Access is a write
   output logic [1:0] o_mem_size,         // Size code
   output logic [31:0] o_mem_addr,        // Byte address
   output logic [31:0] o_mem_wdata,       // Write data, low aligned
   output logic o_wb_en,                  // Register written
   output logic [3:0] o_wb_idx,           // Written register
   output logic [31:0] o_wb_data          // Written value
);
   import lsd_pkg::*;

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      lsd_state_e fsm;                    // Sequencer state
      logic [LSD_NREG-1:0][31:0] regs;    // General registers
      logic ready;                        // Opcode ready
      logic req;                          // Bus request
      logic we;                           // Write access
      logic [1:0] size;                   // Access size
      logic [31:0] addr;                  // Access address
      logic [31:0] wdata;                 // Store data
      logic is_load;                      // Pending load
      logic postinc;                      // Bump base after load
      logic sext;                         // Extend load data
      logic [3:0] rd;                     // Load destination
      logic [3:0] rm;                     // Post-increment register
      logic wb_en;                        // Write-back strobe
      logic [3:0] wb_idx;                 // Write-back index
      logic [31:0] wb_data;               // Write-back value
   } lsd_core_s;

   lsd_core_s st;        // Registered state
   lsd_core_s next_st;   // Next state
   lsd_dec_if dif();     // Decoded opcode
   logic take;           // Opcode accepted this cycle
   logic [31:0] base_val; // Selected base
   logic [31:0] ld_val;  // Extended load value

   assign dif.insn = i_insn;
   assign take = st.ready && i_insn_valid;

   lsd_decode u_dec
   (
      .d (dif)
   );

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb
   begin
      next_st = st;
      next_st.wb_en = 1'b0;
      case (dif.base)
         LSD_BASE_RM: base_val = st.regs[dif.source_reg_field];
         LSD_BASE_PC: base_val = i_insn_pc;
         default: base_val = st.regs[dif.dest_reg_field];
      endcase
      case (st.size)
         LSD_SZ_BYTE: ld_val = st.sext ? lsd_sext8(i_mem_rdata[7:0])
                                      : {24'h0, i_mem_rdata[7:0]};
         LSD_SZ_WORD: ld_val = st.sext ? lsd_sext16(i_mem_rdata[15:0])
                                      : {16'h0, i_mem_rdata[15:0]};
         default: ld_val = i_mem_rdata;
      endcase
      case (st.fsm)
         LSD_ST_READY:
         begin
            if (take)
            begin
               case (dif.op)
                  LSD_OP_IMM:
                  begin
                     // Finishes in the accepting cycle
                     next_st.regs[dif.dst] = lsd_sext8(i_insn[7:0]);
                     next_st.wb_en = 1'b1;
                     next_st.wb_idx = dif.dst;
                     next_st.wb_data = lsd_sext8(i_insn[7:0]);
                  end
                  LSD_OP_MOVRR:
                  begin
                     next_st.regs[dif.dst] = st.regs[dif.source_reg_field];
                     next_st.wb_en = 1'b1;
                     next_st.wb_idx = dif.dst;
                     next_st.wb_data = st.regs[dif.source_reg_field];
                  end
                  LSD_OP_LOAD, LSD_OP_STORE:
                  begin
                     next_st.we = (dif.op == LSD_OP_STORE);
                     next_st.is_load = (dif.op == LSD_OP_LOAD);
                     next_st.size = dif.size;
                     next_st.sext = dif.sext;
                     next_st.postinc = dif.postinc;
                     next_st.rd = dif.dst;
                     next_st.rm = dif.source_reg_field;
                     next_st.wdata = dif.src_r0 ? st.regs[LSD_R0]
                                    : st.regs[dif.source_reg_field];
                     if (dif.predec)
                     begin
                        // Base moves down before the store
                        next_st.addr = st.regs[dif.dest_reg_field]
                                     - lsd_size_bytes(dif.size);
                        next_st.regs[dif.dest_reg_field] = next_st.addr;
                     end
                     else if (dif.use_index)
                        next_st.addr = base_val + st.regs[LSD_R0];
                     else
                        next_st.addr = base_val + dif.disp;
                     next_st.ready = 1'b0;
                     // Request only when fetch leaves the bus
                     next_st.req = !i_fetch_busy;
                     next_st.fsm = i_fetch_busy ? LSD_ST_ISSUE
                                                : LSD_ST_MEM;
                  end
                  default: next_st.ready = 1'b1;
               endcase
            end
         end
         LSD_ST_ISSUE:
         begin
            // Added cycles while fetch holds the bus
            if (!i_fetch_busy)
            begin
               next_st.req = 1'b1;
               next_st.fsm = LSD_ST_MEM;
            end
         end
         LSD_ST_MEM:
         begin
            // Next opcode waits here until the load or store is acknowledged
            if (i_mem_ack)
            begin
               next_st.req = 1'b0;
               next_st.ready = 1'b1;
               next_st.fsm = LSD_ST_READY;
               if (st.is_load)
               begin
                  next_st.regs[st.rd] = ld_val;
                  next_st.wb_en = 1'b1;
                  next_st.wb_idx = st.rd;
                  next_st.wb_data = ld_val;
               end
               if (st.is_load && st.postinc)
                  next_st.regs[st.rm] = st.regs[st.rm]
                                      + lsd_size_bytes(st.size);
            end
         end
         default: next_st.fsm = LSD_ST_READY;
      endcase
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         st <= '0;
         st.regs <= {LSD_NREG{LSD_REG_RST}};
         st.ready <= 1'b1;
         st.size <= LSD_SZ_LONG;
      end
      else
         st <= next_st;
   end

   assign o_insn_ready = st.ready;
   assign o_mem_req = st.req;
   assign o_mem_we = st.we;
   assign o_mem_size = st.size;
   assign o_mem_addr = st.addr;
   assign o_mem_wdata = st.wdata;
   assign o_wb_en = st.wb_en;
   assign o_wb_idx = st.wb_idx;
   assign o_wb_data = st.wb_data;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   chk_imm_one_cycle: assert property (@(posedge i_ref_clk)
      disable iff (!i_rst_n)
      take && dif.op == LSD_OP_IMM |=> o_insn_ready && o_wb_en)
      else $error("immediate move took more than one cycle");

   chk_fetch_yield: assert property (@(posedge i_ref_clk)
      disable iff (!i_rst_n)
      st.fsm == LSD_ST_ISSUE && i_fetch_busy |=> !o_mem_req)
      else $error("data request raised during fetch");

   chk_load_stall: assert property (@(posedge i_ref_clk)
      disable iff (!i_rst_n)
      o_mem_req && !i_mem_ack |=> !o_insn_ready)
      else $error("opcode taken before load data");

   chk_imm_sext: assert property (@(posedge i_ref_clk)
      disable iff (!i_rst_n)
      take && dif.op == LSD_OP_IMM
      |=> o_wb_data == {{24{$past(i_insn[7])}}, $past(i_insn[7:0])})
      else $error("immediate not sign-extended");

   chk_predec_addr: assert property (@(posedge i_ref_clk)
      disable iff (!i_rst_n)
      take && dif.op == LSD_OP_STORE && dif.predec && dif.size == 2'h2
      |=> o_mem_addr == $past(st.regs[dif.dest_reg_field]) - 32'h4)
      else $error("pre-decrement address wrong");

   chk_post_inc: assert property (@(posedge i_ref_clk)
      disable iff (!i_rst_n)
      o_mem_req && i_mem_ack && st.is_load && st.postinc
      && st.rm != st.rd && st.size == 2'h1
      |=> st.regs[$past(st.rm)] == $past(st.regs[st.rm]) + 32'h2)
      else $error("post-increment amount wrong");

   chk_long_load: assert property (@(posedge i_ref_clk)
      disable iff (!i_rst_n)
      o_mem_req && i_mem_ack && st.is_load && st.size == 2'h2
      |=> o_wb_en && o_wb_data == $past(i_mem_rdata))
      else $error("long load altered");

   chk_byte_sext: assert property (@(posedge i_ref_clk)
      disable iff (!i_rst_n)
      o_mem_req && i_mem_ack && st.is_load && st.size == 2'h0
      |=> o_wb_data[31:8] == {24{$past(i_mem_rdata[7])}})
      else $error("byte load not sign-extended");

   chk_disp_store: assert property (@(posedge i_ref_clk)
      disable iff (!i_rst_n)
      take && i_insn[15:8] == 8'h80
      |=> o_mem_addr == $past(st.regs[i_insn[7:4]]) + $past(i_insn[3:0])
          && o_mem_wdata == $past(st.regs[0]))
      else $error("byte displacement store wrong");

endmodule : lsd_core

// ---- lsd_pkg.sv ----
/*
 File: shared constants, types and helpers of the load/store decoder.
 Assumes: included first; one 20 MHz clock, active-low async reset.
*/
package lsd_pkg;

   // ---------------------------------------------------------------
   // Widths and reset values
   // ---------------------------------------------------------------
   localparam int LSD_NREG = 16;               // General registers
   localparam logic [31:0] LSD_REG_RST = 32'h0000_0000; // Register reset
   localparam logic [1:0] LSD_SZ_BYTE = 2'h0;  // Byte size code
   localparam logic [1:0] LSD_SZ_WORD = 2'h1;  // Word size code
   localparam logic [1:0] LSD_SZ_LONG = 2'h2;  // Long size code
   localparam logic [3:0] LSD_R0 = 4'h0;       // Index register zero

   // ---------------------------------------------------------------
   // Enumerations
   // ---------------------------------------------------------------
   typedef enum logic [2:0]
   {
      LSD_OP_NONE = 3'b000,   // Not a transfer of this class
      LSD_OP_IMM = 3'b001,    // Immediate move
      LSD_OP_MOVRR = 3'b010,  // Register to register move
      LSD_OP_LOAD = 3'b011,   // Memory to register
      LSD_OP_STORE = 3'b100   // Register to memory
   } lsd_op_e;

   typedef enum logic [1:0]
   {
      LSD_BASE_RN = 2'b00,    // Destination register field
      LSD_BASE_RM = 2'b01,    // Source register field
      LSD_BASE_PC = 2'b10     // Program counter
   } lsd_base_e;

   typedef enum logic [1:0]
   {
      LSD_ST_READY = 2'b00,   // Accepting instructions
      LSD_ST_ISSUE = 2'b01,   // Waiting for the bus
      LSD_ST_MEM = 2'b10      // Access on the bus
   } lsd_state_e;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] lsd_sext8(input logic [7:0] v);
      lsd_sext8 = {{24{v[7]}}, v};
   endfunction : lsd_sext8

   function automatic logic [31:0] lsd_sext16(input logic [15:0] v);
      lsd_sext16 = {{16{v[15]}}, v};
   endfunction : lsd_sext16

   // Bytes moved by a size code
   function automatic logic [31:0] lsd_size_bytes(input logic [1:0] sz);
      case (sz)
         LSD_SZ_BYTE: lsd_size_bytes = 32'h0000_0001;
         LSD_SZ_WORD: lsd_size_bytes = 32'h0000_0002;
         default: lsd_size_bytes = 32'h0000_0004;
      endcase
   endfunction : lsd_size_bytes

endpackage : lsd_pkg

// ---- lsd_dec_if.sv ----
/*
 File: interface carrying one decoded transfer instruction.
 Assumes: the decoder drives it combinationally from the opcode.
*/
`timescale 1ns/1ps
interface lsd_dec_if;
   import lsd_pkg::*;
   logic [15:0] insn;         // Opcode under decode
   lsd_op_e op;               // Operation class
   logic [1:0] size;          // Access size code
   logic [3:0] dest_reg_field;   // Base or written register
   logic [3:0] source_reg_field; // Source or load base register
   logic [3:0] dst;           // Register written by the result
   lsd_base_e base;           // Address base select
   logic use_index;           // Add index register zero
   logic [31:0] disp;         // Scaled zero-extended displacement
   logic predec;              // Pre-decrement the base
   logic postinc;             // Post-increment the base
   logic src_r0;              // Store data from register zero
   logic sext;                // Sign-extend load data
   modport dec (input insn, output op, size, dest_reg_field,
                source_reg_field, dst, base, use_index, disp,
                predec, postinc, src_r0, sext);
   modport exe (output insn, input op, size, dest_reg_field,
                source_reg_field, dst, base, use_index, disp,
                predec, postinc, src_r0, sext);
endinterface : lsd_dec_if

// ---- lsd_decode.sv ----
/*
 File: combinational opcode decoder for the transfer class.
 Assumes: opcode held stable by the executing module.
*/
`timescale 1ns/1ps
module lsd_decode
(
   lsd_dec_if.dec d   // Decoded fields
);
   import lsd_pkg::*;

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   always_comb
   begin
      d.op = LSD_OP_NONE;
      d.size = LSD_SZ_LONG;
      d.dest_reg_field = d.insn[11:8];
      d.source_reg_field = d.insn[7:4];
      d.dst = d.insn[11:8];
      d.base = LSD_BASE_RN;
      d.use_index = 1'b0;
      d.disp = 32'h0000_0000;
      d.predec = 1'b0;
      d.postinc = 1'b0;
      d.src_r0 = 1'b0;
      d.sext = 1'b0;
      // No decode path touches the status flags
      case (d.insn[15:12])
         4'hE: d.op = LSD_OP_IMM;
         4'h9:
         begin
            // PC-relative word load
            d.op = LSD_OP_LOAD;
            d.size = LSD_SZ_WORD;
            d.base = LSD_BASE_PC;
            d.disp = {23'h0, d.insn[7:0], 1'b0};
            d.sext = 1'b1;
         end
         4'hD:
         begin
            // PC-relative long load
            d.op = LSD_OP_LOAD;
            d.base = LSD_BASE_PC;
            d.disp = {22'h0, d.insn[7:0], 2'b00};
         end
         4'h6:
         begin
            // Register moves and indirect loads
            if (d.insn[3:0] == 4'h3)
               d.op = LSD_OP_MOVRR;
            else if (d.insn[1:0] != 2'b11 && d.insn[3] == 1'b0)
            begin
               d.op = LSD_OP_LOAD;
               d.size = d.insn[1:0];
               d.base = LSD_BASE_RM;
               d.sext = (d.insn[1:0] != LSD_SZ_LONG);
               d.postinc = d.insn[2];
            end
         end
         4'h2:
         begin
            // Indirect and pre-decrement stores
            if (d.insn[1:0] != 2'b11 && d.insn[3] == 1'b0)
            begin
               d.op = LSD_OP_STORE;
               d.size = d.insn[1:0];
               d.predec = d.insn[2];
            end
         end
         4'h8:
         begin
            // Short displacement forms on register zero
            d.disp = {27'h0, d.insn[3:0], 1'b0} >> ~d.insn[8];
            d.size = {1'b0, d.insn[8]};
            d.src_r0 = 1'b1;
            d.dest_reg_field = d.insn[7:4];
            d.dst = LSD_R0;
            if (d.insn[11:9] == 3'b000)
               d.op = LSD_OP_STORE;
            else if (d.insn[11:9] == 3'b010)
            begin
               d.op = LSD_OP_LOAD;
               d.base = LSD_BASE_RM;
               d.sext = 1'b1;
            end
         end
         4'h1:
         begin
            // Long displacement store
            d.op = LSD_OP_STORE;
            d.disp = {26'h0, d.insn[3:0], 2'b00};
         end
         4'h5:
         begin
            // Long displacement load
            d.op = LSD_OP_LOAD;
            d.base = LSD_BASE_RM;
            d.disp = {26'h0, d.insn[3:0], 2'b00};
         end
         4'h0:
         begin
            // Indexed byte and word stores
            if (d.insn[3:1] == 3'b010)
            begin
               d.op = LSD_OP_STORE;
               d.size = {1'b0, d.insn[0]};
               d.use_index = 1'b1;
            end
         end
         default: d.op = LSD_OP_NONE;
      endcase
   end

endmodule : lsd_decode

// ---- lsd_mem_model.sv ----
/*
 File: data memory model that answers the core's access requests.
 Assumes: same clock as the core; the bench sets data and wait count.
*/
`timescale 1ns/1ps
module lsd_mem_model
(
   input wire logic i_ref_clk,     // Core clock
   input wire logic i_rst_n,       // Async reset, active low
   input wire logic i_req,         // Access request from the core
   input wire logic [31:0] i_data, // Value returned by reads
   input wire logic [3:0] i_wait,  // Wait cycles before acknowledge
   output logic o_ack,             // Access done this cycle
   output logic [31:0] o_rdata     // Read data, valid only with ack
);
   // ---------------------------------------------------------------
   // Wait counting and data lines
   // ---------------------------------------------------------------
   logic [3:0] cnt;   // Cycles the current request has waited
   logic [31:0] last; // Last value shown on the data lines

   // Acknowledge once the request has waited long enough
   assign o_ack = i_req && (cnt == i_wait);
   // Outside an acknowledge the lines show the inverse of the last value
   assign o_rdata = o_ack ? i_data : ~last;

   // Count wait cycles and remember the last data shown
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cnt <= 4'h0;
         last <= 32'h0000_0000;
      end
      else
      begin
         cnt <= (i_req && !o_ack) ? cnt + 4'h1 : 4'h0;
         if (o_ack)
            last <= i_data;
      end
   end
endmodule : lsd_mem_model

// ---- tb_load_store_insn_decoder.sv ----
/*
 File: self-checking bench of the load/store decoder core.
 Assumes: lsd_mem_model answers the data bus; one 20 MHz clock.
*/
`timescale 1ns/1ps
module tb_load_store_insn_decoder;
   import lsd_pkg::*;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic clk, rst_n, valid, fbusy, ack, ready, req, we, wb_en; // Controls
   logic [15:0] insn;                               // Opcode offered
   logic [31:0] pc, rdata, addr, wdata, wb_data, mdata; // Data paths
   logic [1:0] size;                                // Access size
   logic [3:0] wb_idx, mwait;                       // Index, wait count
   int mismatches = 0;                              // Failed compares
   int n_checks = 0;                                // All compares

   lsd_core u_dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_insn_valid(valid),
      .i_insn(insn), .i_insn_pc(pc), .i_fetch_busy(fbusy), .i_mem_ack(ack),
      .i_mem_rdata(rdata), .o_insn_ready(ready), .o_mem_req(req),
      .o_mem_we(we), .o_mem_size(size), .o_mem_addr(addr),
      .o_mem_wdata(wdata), .o_wb_en(wb_en), .o_wb_idx(wb_idx),
      .o_wb_data(wb_data));
   lsd_mem_model u_mem (.i_ref_clk(clk), .i_rst_n(rst_n), .i_req(req),
      .i_data(mdata), .i_wait(mwait), .o_ack(ack), .o_rdata(rdata));

   // Free-running 50 ns clock
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // Offer an opcode and hold it until the take edge has passed
   task automatic issue(input logic [15:0] op);
      int i;
      @(posedge clk) #1;
      insn = op;
      valid = 1'b1;
      for (i = 0; i < 20 && ready !== 1'b1; i++)
         @(posedge clk) #1;
      @(posedge clk) #1;
      valid = 1'b0;
   endtask : issue

   // Wait for a register write and compare index and value
   task automatic wait_wb(input logic [3:0] idx, input logic [31:0] exp);
      int i;
      for (i = 0; i < 10 && wb_en !== 1'b1; i++)
         @(posedge clk) #1;
      chk("wb_en", {31'h0, wb_en}, 32'h1);
      chk("wb_idx", {28'h0, wb_idx}, {28'h0, idx});
      chk("wb_data", wb_data, exp);
   endtask : wait_wb

   // Wait for a bus request and compare what qualifies it
   task automatic wait_req(input logic [31:0] a, input logic w,
      input logic [1:0] sz, input logic [31:0] d);
      int i;
      for (i = 0; i < 10 && req !== 1'b1; i++)
         @(posedge clk) #1;
      chk("mem_addr", addr, a);
      chk("mem_we", {31'h0, we}, {31'h0, w});
      chk("mem_size", {30'h0, size}, {30'h0, sz});
      if (w)
         chk("mem_wdata", wdata, d);
   endtask : wait_req

   // Read a register back by moving it into the scratch register
   task automatic rd(input logic [3:0] r, input logic [31:0] exp);
      issue({4'h6, 4'hF, r, 4'h3});
      wait_wb(4'hF, exp);
   endtask : rd

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_imm;
      issue(16'hE010);
      chk("wb_en_next", {31'h0, wb_en}, 32'h1);
      wait_wb(4'h0, 32'h0000_0010);
      issue(16'hE180);
      wait_wb(4'h1, 32'hFFFF_FF80);
      issue(16'hE27F);
      wait_wb(4'h2, 32'h0000_007F);
      issue(16'hE340);
      wait_wb(4'h3, 32'h0000_0040);
      $display("test immediate done");
   endtask : t_imm

   task automatic t_store;
      issue(16'h2326);
      wait_req(32'h0000_003C, 1'b1, LSD_SZ_LONG, 32'h0000_007F);
      issue(16'h2324);
      wait_req(32'h0000_003B, 1'b1, LSD_SZ_BYTE, 32'h0000_007F);
      rd(4'h3, 32'h0000_003B);
      issue(16'h8035);
      wait_req(32'h0000_0040, 1'b1, LSD_SZ_BYTE, 32'h0000_0010);
      issue(16'h813F);
      wait_req(32'h0000_0059, 1'b1, LSD_SZ_WORD, 32'h0000_0010);
      issue(16'h132F);
      wait_req(32'h0000_0077, 1'b1, LSD_SZ_LONG, 32'h0000_007F);
      issue(16'h0324);
      wait_req(32'h0000_004B, 1'b1, LSD_SZ_BYTE, 32'h0000_007F);
      issue(16'h0325);
      wait_req(32'h0000_004B, 1'b1, LSD_SZ_WORD, 32'h0000_007F);
      // Plain register-indirect stores, no base change
      issue(16'h2320);
      wait_req(32'h0000_003B, 1'b1, LSD_SZ_BYTE, 32'h0000_007F);
      issue(16'h2131);
      wait_req(32'hFFFF_FF80, 1'b1, LSD_SZ_WORD, 32'h0000_003B);
      $display("test stores done");
   endtask : t_store

   task automatic t_load;
      mdata = 32'h1234_D680;
      mwait = 4'h2;
      issue(16'h6434);
      wait_req(32'h0000_003B, 1'b0, LSD_SZ_BYTE, 32'h0);
      wait_wb(4'h4, 32'hFFFF_FF80);
      issue(16'h6435);
      wait_req(32'h0000_003C, 1'b0, LSD_SZ_WORD, 32'h0);
      wait_wb(4'h4, 32'hFFFF_D680);
      issue(16'h6436);
      wait_req(32'h0000_003E, 1'b0, LSD_SZ_LONG, 32'h0);
      wait_wb(4'h4, 32'h1234_D680);
      rd(4'h3, 32'h0000_0042);
      // Plain indirect loads leave the base alone
      issue(16'h6A30);
      wait_req(32'h0000_0042, 1'b0, LSD_SZ_BYTE, 32'h0);
      wait_wb(4'hA, 32'hFFFF_FF80);
      issue(16'h6B32);
      wait_req(32'h0000_0042, 1'b0, LSD_SZ_LONG, 32'h0);
      wait_wb(4'hB, 32'h1234_D680);
      // Short displacement loads into register zero, then a long displacement load and a PC-relative word load
      issue(16'h8432);
      wait_req(32'h0000_0044, 1'b0, LSD_SZ_BYTE, 32'h0);
      wait_wb(4'h0, 32'hFFFF_FF80);
      issue(16'h8531);
      wait_req(32'h0000_0044, 1'b0, LSD_SZ_WORD, 32'h0);
      wait_wb(4'h0, 32'hFFFF_D680);
      issue(16'h5532);
      wait_req(32'h0000_004A, 1'b0, LSD_SZ_LONG, 32'h0);
      wait_wb(4'h5, 32'h1234_D680);
      pc = 32'h0000_0100;
      issue(16'h9603);
      wait_req(32'h0000_0106, 1'b0, LSD_SZ_WORD, 32'h0);
      wait_wb(4'h6, 32'hFFFF_D680);
      // PC-relative long load, displacement times four
      issue(16'hD702);
      wait_req(32'h0000_0108, 1'b0, LSD_SZ_LONG, 32'h0);
      wait_wb(4'h7, 32'h1234_D680);
      $display("test loads done");
   endtask : t_load

   task automatic t_stall;
      fbusy = 1'b1;
      issue(16'h1320);
      repeat (3)
      begin
         chk("req_held", {31'h0, req}, 32'h0);
         @(posedge clk) #1;
      end
      fbusy = 1'b0;
      wait_req(32'h0000_0042, 1'b1, LSD_SZ_LONG, 32'h0000_007F);
      mdata = 32'h0000_0055;
      mwait = 4'h1;
      issue(16'h6732);
      chk("ready_low", {31'h0, ready}, 32'h0);
      issue(16'h6873);
      wait_wb(4'h8, 32'h0000_0055);
      $display("test stalls done");
   endtask : t_stall

   // Print the counts and the verdict, then stop
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict

   // Main sequence: reset for four cycles, then every scenario
   initial
   begin
      rst_n = 1'b0;
      valid = 1'b0;
      fbusy = 1'b0;
      insn = 16'h0000;
      pc = 32'h0000_0000;
      mdata = 32'h0000_0000;
      mwait = 4'h0;
      repeat (4) @(posedge clk);
      #1 rst_n = 1'b1;
      t_imm();
      t_store();
      t_load();
      t_stall();
      give_verdict();
   end

   // Watchdog cuts a hang short
   initial
   begin
      #100000;
      mismatches++;
      give_verdict();
   end
endmodule : tb_load_store_insn_decoder
